// *** src/servo_seq_regs.svh ***
// Purpose: Constants for the servo sequence monitor.
// Assumes: Speeds in r/min as unsigned 16-bit magnitudes, times in ms.
// Notes:   Included by the package and the design modules.
`ifndef SERVO_SEQ_REGS_SVH
`define SERVO_SEQ_REGS_SVH

`define SPEED_W              16
`define ZERO_SPEED_DEFAULT   16'h0032
`define AT_SPEED_DEFAULT     16'h0032
`define THRESH_MIN           16'h000a
`define THRESH_MAX           16'h4e20
`define HYSTERESIS_RPM       16'h000a
`define UV_TRIP_DEFAULT      1'b1
`define POWER_OFF_DISABLE    16'h03e8
`define OT_SEQ_DEFAULT       2'h0
`define OT_SEQ_DB_THEN_ZERO  2'h0
`define OT_SEQ_ZERO_TORQUE   2'h1
`define OT_SEQ_ESTOP         2'h2
`define CLOCK_KHZ            125000
`define MS_TICK_CYCLES       17'd125000

`endif

// *** src/servo_seq_pkg.sv ***
// Purpose: Types shared by the servo sequence monitor files.
// Assumes: Constants come from the register header.
// Notes:   Nothing here is imported; users write the package name.
`include "servo_seq_regs.svh"

package servo_seq_pkg;

  typedef struct packed {
    logic [`SPEED_W-1:0] zero_speed_threshold;
    logic [`SPEED_W-1:0] at_speed_threshold;
    logic                undervoltage_trip_select;
    logic [`SPEED_W-1:0] power_off_detect_time;
    logic [1:0]          overtravel_stop_sequence;
  } servo_cfg_t;

  typedef struct packed {
    logic zero_speed_flag;
    logic speed_match_flag;
    logic at_speed_flag;
  } speed_flags_t;

  typedef struct packed {
    logic dynamic_brake;
    logic zero_torque_ccw;
    logic zero_torque_cw;
    logic emergency_stop;
    logic hold_deviation;
  } stop_action_t;

  typedef enum logic [1:0] {
    PWR_ON      = 2'b00,
    PWR_DISENG  = 2'b01,
    PWR_TRIPPED = 2'b10
  } pwr_state_t;

endpackage

// *** src/speed_hyst_cmp.sv ***
// Purpose: Magnitude comparator with a hysteresis band around a threshold.
// Assumes: Speeds are signed two's complement r/min values.
// Notes:   Mode below asserts under the threshold, otherwise above it.
`include "servo_seq_regs.svh"

module speed_hyst_cmp (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       below_mode,
  input  wire logic signed [`SPEED_W:0]   value,
  input  wire logic        [`SPEED_W-1:0] threshold,
  output logic                            flag
);

  logic              flag_ff;
  logic              nxt_flag;
  logic [`SPEED_W:0] mag;
  logic [`SPEED_W:0] upper;
  logic [`SPEED_W:0] lower;

  // Magnitude only, so either rotation direction compares alike.
  always_comb begin
    mag   = value[`SPEED_W] ? (`SPEED_W+1)'(-value) : value;
    upper = {1'b0, threshold} + {1'b0, `HYSTERESIS_RPM};
    lower = (threshold > `HYSTERESIS_RPM) ? {1'b0, threshold - `HYSTERESIS_RPM}
                                          : {(`SPEED_W+1){1'b0}};
    nxt_flag = flag_ff;
    if (below_mode) begin
      if (mag < lower) begin
        nxt_flag = 1'b1;
      end else if (mag > upper) begin
        nxt_flag = 1'b0;
      end
    end else begin
      if (mag > upper) begin
        nxt_flag = 1'b1;
      end else if (mag < lower) begin
        nxt_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule

// *** src/servo_sequence_monitor.sv ***
// Purpose: Speed status flags, main power loss handling and over-travel stop selection.
// Assumes: 125 MHz clock; speeds arrive as synchronous signed r/min samples.
// Notes:   Power and inhibit pins pass a three-stage synchroniser.
`include "servo_seq_regs.svh"

module servo_sequence_monitor (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire servo_seq_pkg::servo_cfg_t   cfg,
  input  wire logic signed [`SPEED_W:0]    motor_speed,
  input  wire logic signed [`SPEED_W:0]    command_speed,
  input  wire logic                        servo_on_request,
  input  wire logic                        main_power_ok_pin,
  input  wire logic                        bus_voltage_low_pin,
  input  wire logic                        ccw_travel_inhibit,
  input  wire logic                        cw_travel_inhibit,
  input  wire logic                        motor_stalled,
  input  wire logic                        alarm_clear,
  output servo_seq_pkg::speed_flags_t      flags,
  output logic                             servo_engaged,
  output logic                             main_undervoltage_alarm,
  output logic                             main_power_lost,
  output servo_seq_pkg::stop_action_t      stop_action
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Each pin shifts through three flops, and a new level is taken only once
  // the second and third stages agree, which rejects single-cycle glitches.
  logic [2:0] pwr_sync_ff;
  logic [2:0] bus_sync_ff;
  logic [2:0] ccw_sync_ff;
  logic [2:0] cw_sync_ff;
  logic [2:0] nxt_pwr_sync;
  logic [2:0] nxt_bus_sync;
  logic [2:0] nxt_ccw_sync;
  logic [2:0] nxt_cw_sync;
  logic       pwr_ok_ff;
  logic       bus_low_ff;
  logic       ccw_inh_ff;
  logic       cw_inh_ff;
  logic       nxt_pwr_ok;
  logic       nxt_bus_low;
  logic       nxt_ccw_inh;
  logic       nxt_cw_inh;

  // The current level is kept while the last two stages disagree.
  function automatic logic settle(input logic [2:0] s, input logic cur);
    settle = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // Only the second stage reads the first stage.
  always_comb begin
    nxt_pwr_sync = {pwr_sync_ff[1:0], main_power_ok_pin};
    nxt_bus_sync = {bus_sync_ff[1:0], bus_voltage_low_pin};
    nxt_ccw_sync = {ccw_sync_ff[1:0], ccw_travel_inhibit};
    nxt_cw_sync  = {cw_sync_ff[1:0], cw_travel_inhibit};
    nxt_pwr_ok   = settle(pwr_sync_ff, pwr_ok_ff);
    nxt_bus_low  = settle(bus_sync_ff, bus_low_ff);
    nxt_ccw_inh  = settle(ccw_sync_ff, ccw_inh_ff);
    nxt_cw_inh   = settle(cw_sync_ff, cw_inh_ff);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Power resets to present so that start-up never reports a false loss.
      pwr_sync_ff <= 3'h7;
      bus_sync_ff <= 3'h0;
      ccw_sync_ff <= 3'h0;
      cw_sync_ff  <= 3'h0;
      pwr_ok_ff   <= 1'b1;
      bus_low_ff  <= 1'b0;
      ccw_inh_ff  <= 1'b0;
      cw_inh_ff   <= 1'b0;
    end else begin
      pwr_sync_ff <= nxt_pwr_sync;
      bus_sync_ff <= nxt_bus_sync;
      ccw_sync_ff <= nxt_ccw_sync;
      cw_sync_ff  <= nxt_cw_sync;
      pwr_ok_ff   <= nxt_pwr_ok;
      bus_low_ff  <= nxt_bus_low;
      ccw_inh_ff  <= nxt_ccw_inh;
      cw_inh_ff   <= nxt_cw_inh;
    end
  end

  // ************************************************************
  // Speed flags
  // ************************************************************
  logic signed [`SPEED_W:0] speed_diff;
  logic                     zero_flag;
  logic                     match_flag;
  logic                     at_flag;

  // The match flag applies the zero speed threshold to the command error.
  // Two speeds within the rated range differ by a value that fits 17 bits.
  always_comb begin
    speed_diff = (`SPEED_W+1)'(command_speed - motor_speed);
  end

  // Each comparator holds its flag while the value sits inside the band.
  speed_hyst_cmp u_zero (
    .clock       (clock),
    .rst_n       (rst_n),
    .below_mode  (1'b1),
    .value       (motor_speed),
    .threshold   (cfg.zero_speed_threshold),
    .flag        (zero_flag)
  );

  speed_hyst_cmp u_match (
    .clock       (clock),
    .rst_n       (rst_n),
    .below_mode  (1'b1),
    .value       (speed_diff),
    .threshold   (cfg.zero_speed_threshold),
    .flag        (match_flag)
  );

  speed_hyst_cmp u_at (
    .clock       (clock),
    .rst_n       (rst_n),
    .below_mode  (1'b0),
    .value       (motor_speed),
    .threshold   (cfg.at_speed_threshold),
    .flag        (at_flag)
  );

  assign flags.zero_speed_flag  = zero_flag;
  assign flags.speed_match_flag = match_flag;
  assign flags.at_speed_flag    = at_flag;

  // ************************************************************
  // Millisecond tick and power-off timer
  // ************************************************************
  // The tick runs free from reset, so a detection time of N is met after
  // between N-1 and N whole milliseconds of continuous loss.
  logic [16:0]         tick_cnt_ff;
  logic [16:0]         nxt_tick_cnt;
  logic                ms_tick;
  logic [`SPEED_W-1:0] off_ms_ff;
  logic [`SPEED_W-1:0] nxt_off_ms;
  logic                detect_done;

  always_comb begin
    ms_tick      = (tick_cnt_ff == `MS_TICK_CYCLES - 17'd1);
    nxt_tick_cnt = ms_tick ? 17'd0 : tick_cnt_ff + 17'd1;
    nxt_off_ms   = off_ms_ff;
    // The off counter saturates so a long outage never wraps back to zero.
    if (pwr_ok_ff) begin
      nxt_off_ms = '0;
    end else if (ms_tick && off_ms_ff != 16'hffff) begin
      nxt_off_ms = off_ms_ff + 16'h0001;
    end
    // Loss is declared only once the shutoff lasts the programmed time.
    detect_done = !pwr_ok_ff && (off_ms_ff >= cfg.power_off_detect_time);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 17'd0;
      off_ms_ff   <= 16'h0000;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      off_ms_ff   <= nxt_off_ms;
    end
  end

  // ************************************************************
  // Main power sequence
  // ************************************************************
  servo_seq_pkg::pwr_state_t state_ff;
  servo_seq_pkg::pwr_state_t nxt_state;
  logic                      trip_mode;

  always_comb begin
    // A detection time of 1000 forces the tripping behaviour.
    trip_mode = cfg.undervoltage_trip_select
              || (cfg.power_off_detect_time == `POWER_OFF_DISABLE);
    nxt_state = state_ff;
    case (state_ff)
      servo_seq_pkg::PWR_ON: begin
        // A bus collapse with main power lost trips whatever the selection is, while a loss with
        // the servo off is ignored until the servo is requested again.
        if (bus_low_ff && !pwr_ok_ff) begin
          nxt_state = servo_seq_pkg::PWR_TRIPPED;
        end else if (detect_done && servo_on_request) begin
          if (trip_mode) begin
            nxt_state = servo_seq_pkg::PWR_TRIPPED;
          end else begin
            nxt_state = servo_seq_pkg::PWR_DISENG;
          end
        end
      end
      servo_seq_pkg::PWR_DISENG: begin
        if (bus_low_ff && !pwr_ok_ff) begin
          nxt_state = servo_seq_pkg::PWR_TRIPPED;
        end else if (pwr_ok_ff) begin
          // Restored power alone brings the servo back, with no clear needed.
          nxt_state = servo_seq_pkg::PWR_ON;
        end
      end
      servo_seq_pkg::PWR_TRIPPED: begin
        // The trip is held until it is cleared with power and bus voltage back.
        if (alarm_clear && pwr_ok_ff && !bus_low_ff) begin
          nxt_state = servo_seq_pkg::PWR_ON;
        end
      end
      default: begin
        nxt_state = servo_seq_pkg::PWR_ON;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Reset starts in the on state and the synchronised power pin decides.
      state_ff <= servo_seq_pkg::PWR_ON;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Engagement follows the request only while the sequence is in the on state.
  // Power lost is reported even with the servo off, so the host can see it.
  assign main_undervoltage_alarm = (state_ff == servo_seq_pkg::PWR_TRIPPED);
  assign servo_engaged   = servo_on_request && (state_ff == servo_seq_pkg::PWR_ON);
  assign main_power_lost = detect_done;

  // ************************************************************
  // Over-travel stop sequence
  // ************************************************************
  // The action is registered so the host sees a steady level.
  servo_seq_pkg::stop_action_t nxt_action;
  servo_seq_pkg::stop_action_t action_ff;
  logic                        inhibit_any;

  // Torque is released only toward a side whose inhibit is active.
  function automatic servo_seq_pkg::stop_action_t stall_torque(
    input logic stalled,
    input logic ccw_inh,
    input logic cw_inh
  );
    servo_seq_pkg::stop_action_t act;
    act                 = '0;
    act.hold_deviation  = 1'b1;
    act.zero_torque_ccw = stalled && ccw_inh;
    act.zero_torque_cw  = stalled && cw_inh;
    stall_torque        = act;
  endfunction

  always_comb begin
    inhibit_any = ccw_inh_ff || cw_inh_ff;
    nxt_action  = '0;
    if (inhibit_any) begin
      // Setting 3 names no sequence and falls back to the brake sequence.
      case (cfg.overtravel_stop_sequence)
        `OT_SEQ_DB_THEN_ZERO: begin
          nxt_action = stall_torque(motor_stalled, ccw_inh_ff, cw_inh_ff);
          nxt_action.dynamic_brake = !motor_stalled;
        end
        `OT_SEQ_ZERO_TORQUE: begin
          nxt_action = stall_torque(1'b1, ccw_inh_ff, cw_inh_ff);
        end
        `OT_SEQ_ESTOP: begin
          nxt_action = stall_torque(motor_stalled, ccw_inh_ff, cw_inh_ff);
          nxt_action.emergency_stop = !motor_stalled;
        end
        default: begin
          nxt_action = stall_torque(motor_stalled, ccw_inh_ff, cw_inh_ff);
          nxt_action.dynamic_brake = !motor_stalled;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      action_ff <= '0;
    end else begin
      action_ff <= nxt_action;
    end
  end

  assign stop_action = action_ff;

endmodule

// *** test/servo_seq_monitor.sv ***
// Purpose: Port assertions for the servo sequence monitor.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Attached to the design by the bind at the foot.
module servo_seq_monitor (
  input wire logic                      clock,
  input wire logic                      rst_n,
  input wire servo_seq_pkg::servo_cfg_t cfg,
  input wire logic signed [16:0]        motor_speed,
  input wire logic signed [16:0]        command_speed,
  input wire logic                      servo_on_request,
  input wire logic                      main_power_ok_pin,
  input wire logic                      bus_voltage_low_pin,
  input wire logic                      ccw_travel_inhibit,
  input wire logic                      cw_travel_inhibit,
  input wire logic                      motor_stalled,
  input wire logic                      alarm_clear,
  input wire servo_seq_pkg::speed_flags_t flags,
  input wire logic                      servo_engaged,
  input wire logic                      main_undervoltage_alarm,
  input wire logic                      main_power_lost,
  input wire servo_seq_pkg::stop_action_t stop_action
);
  timeunit 1ns;
  timeprecision 1ps;
  int mag, d, dif, zt, att;
  assign mag = motor_speed < 0 ? -int'(motor_speed) : int'(motor_speed);
  assign d   = int'(command_speed) - int'(motor_speed);
  assign dif = d < 0 ? -d : d;
  assign zt  = int'(cfg.zero_speed_threshold);
  assign att = int'(cfg.at_speed_threshold);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_zero_set: assert property (mag < zt - 10 |=> flags.zero_speed_flag)
    else $error("zero speed flag not set");
  chk_zero_clear: assert property (mag > zt + 10 |=> !flags.zero_speed_flag)
    else $error("zero speed flag not cleared");
  chk_zero_hold: assert property (mag >= zt - 10 && mag <= zt + 10 |=>
    $stable(flags.zero_speed_flag)) else $error("zero speed flag moved in band");
  chk_match_set: assert property (dif < zt - 10 |=> flags.speed_match_flag)
    else $error("speed match flag not set");
  chk_match_clear: assert property (dif > zt + 10 |=> !flags.speed_match_flag)
    else $error("speed match flag not cleared");
  chk_at_set: assert property (mag > att + 10 |=> flags.at_speed_flag)
    else $error("at speed flag not set");
  chk_at_clear: assert property (mag < att - 10 |=> !flags.at_speed_flag)
    else $error("at speed flag not cleared");
  chk_trip_alarm: assert property (main_power_lost && servo_engaged &&
    (cfg.undervoltage_trip_select || cfg.power_off_detect_time == 16'h03e8)
    |=> main_undervoltage_alarm) else $error("power loss did not trip");
  chk_nontrip_off: assert property (main_power_lost && !main_undervoltage_alarm &&
    !cfg.undervoltage_trip_select && cfg.power_off_detect_time != 16'h03e8
    |=> !main_undervoltage_alarm && !servo_engaged) else $error("non-trip loss wrong");
  chk_alarm_hold: assert property (main_undervoltage_alarm && !alarm_clear
    |=> main_undervoltage_alarm) else $error("alarm dropped without clear");
  chk_estop_mode: assert property (stop_action.emergency_stop |->
    cfg.overtravel_stop_sequence == 2'h2 && stop_action.hold_deviation)
    else $error("emergency stop in wrong mode");
endmodule

bind servo_sequence_monitor servo_seq_monitor u_servo_seq_monitor (
  .clock(clock), .rst_n(rst_n), .cfg(cfg), .motor_speed(motor_speed),
  .command_speed(command_speed), .servo_on_request(servo_on_request),
  .main_power_ok_pin(main_power_ok_pin), .bus_voltage_low_pin(bus_voltage_low_pin),
  .ccw_travel_inhibit(ccw_travel_inhibit), .cw_travel_inhibit(cw_travel_inhibit),
  .motor_stalled(motor_stalled), .alarm_clear(alarm_clear), .flags(flags),
  .servo_engaged(servo_engaged), .main_undervoltage_alarm(main_undervoltage_alarm),
  .main_power_lost(main_power_lost), .stop_action(stop_action));

// *** test/host_ctrl_model.sv ***
// Purpose: Host motion controller model driving the over-travel inhibits.
// Assumes: Limit requests from the bench change at the falling edge.
// Notes:   Inhibits change just after a rising edge, as the host would.
module host_ctrl_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic at_ccw_limit,
  input  wire logic at_cw_limit,
  output logic      ccw_travel_inhibit,
  output logic      cw_travel_inhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ccw_travel_inhibit <= 1'b0;
      cw_travel_inhibit  <= 1'b0;
    end else begin
      ccw_travel_inhibit <= at_ccw_limit;
      cw_travel_inhibit  <= at_cw_limit;
    end
  end
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the servo sequence monitor.
// Assumes: 125 MHz clock, inputs driven at the falling edge.
// Notes:   Detection time 0 keeps power-loss runs short.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         clock, rst_n, servo_on_request, main_power_ok_pin;
  logic                         bus_voltage_low_pin, motor_stalled, alarm_clear;
  logic                         limit_ccw, limit_cw, ccw_inh, cw_inh;
  logic                         servo_engaged, main_undervoltage_alarm, main_power_lost;
  logic signed [16:0]           motor_speed, command_speed;
  servo_seq_pkg::servo_cfg_t    cfg;
  servo_seq_pkg::speed_flags_t  flags;
  servo_seq_pkg::stop_action_t  stop_action;
  int                           bad_count, n_checks;

  servo_sequence_monitor u_servo_sequence_monitor (.clock(clock), .rst_n(rst_n), .cfg(cfg),
    .motor_speed(motor_speed), .command_speed(command_speed),
    .servo_on_request(servo_on_request), .main_power_ok_pin(main_power_ok_pin),
    .bus_voltage_low_pin(bus_voltage_low_pin), .ccw_travel_inhibit(ccw_inh),
    .cw_travel_inhibit(cw_inh), .motor_stalled(motor_stalled), .alarm_clear(alarm_clear),
    .flags(flags), .servo_engaged(servo_engaged),
    .main_undervoltage_alarm(main_undervoltage_alarm), .main_power_lost(main_power_lost),
    .stop_action(stop_action));
  host_ctrl_model u_host_ctrl_model (.clock(clock), .rst_n(rst_n), .at_ccw_limit(limit_ccw),
    .at_cw_limit(limit_cw), .ccw_travel_inhibit(ccw_inh), .cw_travel_inhibit(cw_inh));

  always #4 clock = ~clock;

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for alarm (0), power lost (1) or engaged (2) to reach a level.
  task automatic wait_on(input int sel, input logic val);
    logic v;
    for (int i = 0; i < 60; i++) begin
      @(negedge clock);
      v = sel == 0 ? main_undervoltage_alarm : sel == 1 ? main_power_lost : servo_engaged;
      if (v === val) return;
    end
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    test_done();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic speed_table;
    int         spd [9] = '{0, -45, 40, 61, -61, 55, 39, -19989, 20011};
    int         cmd [9] = '{0, 0, 40, 0, -61, 0, 100, 0, -20011};
    int         thr [9] = '{50, 50, 50, 50, 50, 50, 50, 20000, 20000};
    logic [2:0] exp [9] = '{3'h6, 3'h6, 3'h6, 3'h1, 3'h3, 3'h3, 3'h4, 3'h6, 3'h1};
    for (int i = 0; i < 9; i++) begin
      @(negedge clock);
      cfg.zero_speed_threshold = 16'(thr[i]);
      cfg.at_speed_threshold   = 16'(thr[i]);
      motor_speed   = 17'(spd[i]);
      command_speed = 17'(cmd[i]);
      repeat (2) @(negedge clock);
      check(8'(flags), 8'(exp[i]));
    end
  endtask

  task automatic power_trip;
    @(negedge clock);
    servo_on_request  = 1'b0;
    main_power_ok_pin = 1'b0;
    repeat (10) @(negedge clock);
    check(8'({main_power_lost, main_undervoltage_alarm}), 8'h02);
    main_power_ok_pin = 1'b1;
    repeat (6) @(negedge clock);
    servo_on_request  = 1'b1;
    @(negedge clock);
    main_power_ok_pin = 1'b0;
    wait_on(0, 1'b1);
    check(8'(servo_engaged), 8'h00);
    main_power_ok_pin = 1'b1;
    repeat (8) @(negedge clock);
    check(8'(main_undervoltage_alarm), 8'h01);
    alarm_clear = 1'b1;
    wait_on(0, 1'b0);
    alarm_clear = 1'b0;
    wait_on(2, 1'b1);
  endtask

  task automatic power_nontrip;
    @(negedge clock);
    cfg.undervoltage_trip_select = 1'b0;
    main_power_ok_pin = 1'b0;
    wait_on(1, 1'b1);
    @(negedge clock);
    check(8'({main_undervoltage_alarm, servo_engaged}), 8'h00);
    main_power_ok_pin = 1'b1;
    wait_on(2, 1'b1);
    check(8'(main_undervoltage_alarm), 8'h00);
  endtask

  task automatic bus_low_trip;
    @(negedge clock);
    cfg.power_off_detect_time = 16'h0005;
    main_power_ok_pin = 1'b0;
    repeat (20) @(negedge clock);
    check(8'({main_power_lost, main_undervoltage_alarm}), 8'h00);
    bus_voltage_low_pin = 1'b1;
    wait_on(0, 1'b1);
    main_power_ok_pin   = 1'b1;
    bus_voltage_low_pin = 1'b0;
    repeat (8) @(negedge clock);
    check(8'(main_undervoltage_alarm), 8'h01);
    alarm_clear = 1'b1;
    wait_on(0, 1'b0);
    alarm_clear = 1'b0;
  endtask

  task automatic overtravel_all;
    logic [4:0] mid, fin;
    for (int s = 0; s < 4; s++) begin
      @(negedge clock);
      cfg.overtravel_stop_sequence = 2'(s);
      motor_stalled = 1'b0;
      limit_ccw = s != 3;
      limit_cw  = s == 3;
      mid = s == 1 ? 5'h09 : s == 2 ? 5'h03 : 5'h11;
      fin = s == 3 ? 5'h05 : 5'h09;
      repeat (8) @(negedge clock);
      check(8'(stop_action), 8'(mid));
      motor_stalled = 1'b1;
      repeat (3) @(negedge clock);
      check(8'(stop_action), 8'(fin));
      limit_ccw = 1'b0;
      limit_cw  = 1'b0;
      repeat (8) @(negedge clock);
      check(8'(stop_action), 8'h00);
    end
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    cfg = '{16'h0032, 16'h0032, 1'b1, 16'h0000, 2'h0};
    motor_speed = '0;
    command_speed = '0;
    servo_on_request = 1'b1;
    main_power_ok_pin = 1'b1;
    bus_voltage_low_pin = 1'b0;
    motor_stalled = 1'b0;
    alarm_clear = 1'b0;
    limit_ccw = 1'b0;
    limit_cw = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    speed_table();
    power_trip();
    power_nontrip();
    bus_low_trip();
    overtravel_all();
    test_done();
  end
endmodule
